// ### verilog/nvm_access_pkg.sv
// constants, types and reset values of the nonvolatile memory access block
// How it works
// - load bit copies staging into 21-bit address
// - control 0x04 writes staged data at address
// - control 0x08 reads; may take several cycles
// - status bit 7 shows auto-increment enable
// - status bit 6 high while RAM fill runs
// - status bit 5 sets on nonzero result
// - only status register write clears error bit
// - status bit 4 flags last page location
// - auto-increment stops at page end 0x7C..0x7F
// - status bit 2 follows macro busy directly
// - status bits 1:0 hold last result code
// - completed read word held in read data
// - write moves write data into page buffer
// - fill busy blocks bus-issued memory operations
// - reset fill from reset base, instance zero
// - fill absent: outputs low, done high
// - fill copies configured count of 9-bit words
// - four reload requests start configured fill copies
// - ready always high, slave error always low
// - one clock, asynchronous active-low reset
// - auto-increment steps 4 bytes
// - control bit 7 write toggles auto-increment
package nvm_access_pkg;
    localparam int BUS_DATA_BITS      = 32;
    localparam int NVM_ADDR_BITS      = 21;
    localparam int NVM_OFS_BITS       = 18;
    localparam int RAM_FILL_ADDR_BITS = 12;
    localparam int FILL_WORD_BITS     = 9;
    localparam int NUM_RELOAD         = 4;
    localparam int NUM_CFG            = 5;

    localparam logic [4:0] OFS_ADDR1  = 5'h00;
    localparam logic [4:0] OFS_ADDR2  = 5'h04;
    localparam logic [4:0] OFS_ADDR3  = 5'h08;
    localparam logic [4:0] OFS_WDATA  = 5'h0C;
    localparam logic [4:0] OFS_CTRL   = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_RDATA  = 5'h18;

    localparam int CTRL_LOAD    = 0;
    localparam int CTRL_WRITE   = 2;
    localparam int CTRL_READ    = 3;
    localparam int CTRL_PROGRAM = 4;
    localparam int CTRL_AUTOINC = 7;

    localparam int STAT_AUTOINC = 7;
    localparam int STAT_FILL    = 6;
    localparam int STAT_ERROR   = 5;
    localparam int STAT_PAGEEND = 4;
    localparam int STAT_BUSY    = 2;

    localparam logic [7:0]  STATUS_RESET   = 8'h80;
    localparam logic [20:0] AUTO_INC_STEP  = 21'h000004;
    localparam logic [6:0]  PAGE_LAST_OFS  = 7'h7F;
    localparam logic [6:0]  STEP_IGNORED   = 7'h03;
    localparam logic [1:0]  RESULT_OK      = 2'h0;
    localparam logic [1:0]  FILL_INSTANCE  = 2'h0;
    localparam logic [2:0]  CFG_RESET_IDX  = 3'h4;

    // index 0..3 follow the reload requests, index 4 is the reset copy
    localparam logic [17:0] CFG_BASE  [NUM_CFG] = '{18'h00080, 18'h00100, 18'h00180, 18'h00200, 18'h00000};
    localparam logic [11:0] CFG_COUNT [NUM_CFG] = '{12'h010, 12'h010, 12'h010, 12'h010, 12'h010};
    localparam logic        CFG_SPARE [NUM_CFG] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [17:0] base;
        logic [11:0] count;
        logic        spare;
    } fill_cfg_t;

    typedef struct packed {
        logic [20:0] addr;
        logic [31:0] wdata;
        logic        rd;
        logic        wr;
        logic        prog;
    } nvm_cmd_t;

    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FILL_LOAD, ST_FILL_ISSUE, ST_FILL_WAIT} state_t;
    typedef enum {OP_READ, OP_WRITE, OP_PROGRAM} op_t;
endpackage : nvm_access_pkg

// ### verilog/fill_cfg_table.sv
// table of fill copy settings with a registered read port
`timescale 1ns/100ps
module fill_cfg_table (
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    input  wire logic [2:0]                sel_i,
    output nvm_access_pkg::fill_cfg_t      cfg_o
);
    import nvm_access_pkg::*;

    fill_cfg_t table_w [NUM_CFG];

    genvar g;
    generate
        for (g = 0; g < NUM_CFG; g++) begin : g_entry
            assign table_w[g] = '{base: CFG_BASE[g], count: CFG_COUNT[g], spare: CFG_SPARE[g]};
        end
    endgenerate

    // registered read keeps the wide mux off the engine's path
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o <= '0;
        end else if (ce_i) begin
            if (sel_i < 3'(NUM_CFG)) begin
                cfg_o <= table_w[sel_i];
            end else begin
                cfg_o <= '0;
            end
        end
    end
endmodule : fill_cfg_table

// ### verilog/nvm_access.sv
// register access to the nonvolatile memory macro plus the RAM fill engine
`timescale 1ns/100ps
module nvm_access #(
    parameter bit INIT_ENABLED = 1'b1
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  ce_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [4:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  nvm_busy_i,
    input  wire logic [1:0]            nvm_status_i,
    input  wire logic [31:0]           nvm_rdata_i,
    output nvm_access_pkg::nvm_cmd_t   nvm_cmd_o,
    input  wire logic [3:0]            reload_req_i,
    output logic      [11:0]           ram_fill_addr_o,
    output logic      [8:0]            ram_fill_data_o,
    output logic                       ram_fill_valid_o,
    output logic                       init_done_o
);
    import nvm_access_pkg::*;

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    state_t      state_q;
    op_t         kind_q;
    logic [20:0] addr_stage_q;
    logic [20:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [1:0]  result_q;
    logic        err_q;
    logic        autoinc_q;
    logic [3:0]  pend_q;
    logic        rst_fill_q;
    logic        fill_busy_q;
    logic [2:0]  sel_q;
    logic [11:0] fill_idx_q;
    fill_cfg_t   cfg_w;
    fill_cfg_t   fill_q;
    logic        wr_acc;
    logic        setup_rd;
    logic        ctrl_wr;
    logic        op_any;
    logic        fill_start;
    logic        op_go;
    logic        strobe_w;
    logic        done_w;
    logic        fill_word;
    logic        fill_last;
    logic        page_last;
    logic [2:0]  pick;
    logic [7:0]  status_w;

    // reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign wr_acc     = psel_i & penable_i & pwrite_i;
    assign setup_rd   = psel_i & ~penable_i & ~pwrite_i;
    assign ctrl_wr    = wr_acc & (paddr_i == OFS_CTRL);
    assign op_any     = ctrl_wr & (pwdata_i[CTRL_READ] | pwdata_i[CTRL_WRITE] | pwdata_i[CTRL_PROGRAM]);
    assign fill_start = INIT_ENABLED && (state_q == ST_IDLE) && (rst_fill_q || (pend_q != 4'h0));
    // a command that lands while a fill runs or starts is dropped
    assign op_go      = (state_q == ST_IDLE) && !fill_start && op_any;
    assign strobe_w   = nvm_cmd_o.rd | nvm_cmd_o.wr | nvm_cmd_o.prog;
    // the strobe cycle is skipped: the macro raises busy one cycle late
    assign done_w     = (state_q == ST_WAIT) && !strobe_w && !nvm_busy_i;
    assign fill_word  = (state_q == ST_FILL_WAIT) && !strobe_w && !nvm_busy_i;
    assign fill_last  = (fill_idx_q + 12'h001) == fill_q.count;
    // low two bits are not stepped, so the page end is 0x7C..0x7F
    assign page_last  = (addr_q[6:0] | STEP_IGNORED) == PAGE_LAST_OFS;

    always_comb begin
        pick = CFG_RESET_IDX;
        if (!rst_fill_q) begin
            for (int k = NUM_RELOAD - 1; k >= 0; k--) begin
                if (pend_q[k]) begin
                    pick = 3'(k);
                end
            end
        end
    end

    assign status_w = {autoinc_q, fill_busy_q, err_q, page_last, 1'b0, nvm_busy_i, result_q};

    // the table output is registered, so the pick goes in at the start edge for the load state to see it
    fill_cfg_table u_cfg (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n),
        .ce_i      (ce_i),
        .sel_i     (fill_start ? pick : sel_q),
        .cfg_o     (cfg_w)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end
    end

    // read data is latched in the setup cycle so it stands in the access cycle
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= '0;
        end else if (ce_i && setup_rd) begin
            case (paddr_i)
                OFS_ADDR1:  prdata_o <= {11'h000, addr_q};
                OFS_WDATA:  prdata_o <= wdata_q;
                OFS_STATUS: prdata_o <= {24'h000000, status_w};
                OFS_RDATA:  prdata_o <= rdata_q;
                default:    prdata_o <= '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_stage_q <= '0;
            wdata_q      <= '0;
        end else if (ce_i && wr_acc) begin
            if (paddr_i == OFS_ADDR1) begin
                addr_stage_q <= pwdata_i[20:0];
            end
            if (paddr_i == OFS_WDATA) begin
                wdata_q <= pwdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            autoinc_q <= STATUS_RESET[STAT_AUTOINC];
        end else if (ce_i && ctrl_wr && pwdata_i[CTRL_AUTOINC]) begin
            autoinc_q <= !autoinc_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else if (ce_i) begin
            if (ctrl_wr && pwdata_i[CTRL_LOAD]) begin
                addr_q <= addr_stage_q;
            end else if (done_w && autoinc_q && !page_last && kind_q != OP_PROGRAM) begin
                addr_q <= addr_q + AUTO_INC_STEP;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            kind_q <= OP_READ;
        end else if (ce_i && op_go) begin
            if (pwdata_i[CTRL_READ]) begin
                kind_q <= OP_READ;
            end else if (pwdata_i[CTRL_WRITE]) begin
                kind_q <= OP_WRITE;
            end else begin
                kind_q <= OP_PROGRAM;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= RESULT_OK;
            rdata_q  <= '0;
        end else if (ce_i && (done_w || fill_word)) begin
            result_q <= nvm_status_i;
            if (done_w && kind_q == OP_READ) begin
                rdata_q <= nvm_rdata_i;
            end
        end
    end

    // a new error in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= STATUS_RESET[STAT_ERROR];
        end else if (ce_i) begin
            if ((done_w || fill_word) && nvm_status_i != RESULT_OK) begin
                err_q <= 1'b1;
            end else if (wr_acc && paddr_i == OFS_STATUS) begin
                err_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_q     <= 4'h0;
            rst_fill_q <= INIT_ENABLED;
            sel_q      <= CFG_RESET_IDX;
        end else if (ce_i) begin
            if (fill_start) begin
                sel_q      <= pick;
                rst_fill_q <= 1'b0;
            end
            if (INIT_ENABLED) begin
                pend_q <= (pend_q & ~(fill_start && !rst_fill_q ? 4'(1 << pick) : 4'h0)) | reload_req_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (ce_i) begin
            case (state_q)
                ST_IDLE: begin
                    if (fill_start) begin
                        state_q <= ST_FILL_LOAD;
                    end else if (op_go) begin
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (done_w) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_FILL_LOAD: begin
                    state_q <= (cfg_w.count == 12'h000) ? ST_IDLE : ST_FILL_ISSUE;
                end
                ST_FILL_ISSUE: begin
                    state_q <= ST_FILL_WAIT;
                end
                ST_FILL_WAIT: begin
                    if (fill_word) begin
                        state_q <= fill_last ? ST_IDLE : ST_FILL_ISSUE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fill_q      <= '0;
            fill_idx_q  <= '0;
            fill_busy_q <= 1'b0;
        end else if (ce_i) begin
            if (fill_start) begin
                fill_busy_q <= 1'b1;
            end else if ((state_q == ST_FILL_LOAD && cfg_w.count == 12'h000) || (fill_word && fill_last)) begin
                fill_busy_q <= 1'b0;
            end
            if (state_q == ST_FILL_LOAD) begin
                fill_q     <= cfg_w;
                fill_idx_q <= '0;
            end else if (fill_word) begin
                fill_idx_q <= fill_idx_q + 12'h001;
            end
        end
    end

    // strobes are one cycle wide, launched from the issue states
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nvm_cmd_o <= '0;
        end else if (ce_i) begin
            nvm_cmd_o.rd   <= 1'b0;
            nvm_cmd_o.wr   <= 1'b0;
            nvm_cmd_o.prog <= 1'b0;
            if (state_q == ST_ISSUE) begin
                nvm_cmd_o.addr  <= addr_q;
                nvm_cmd_o.wdata <= wdata_q;
                nvm_cmd_o.rd    <= kind_q == OP_READ;
                nvm_cmd_o.wr    <= kind_q == OP_WRITE;
                nvm_cmd_o.prog  <= kind_q == OP_PROGRAM;
            end else if (state_q == ST_FILL_ISSUE) begin
                nvm_cmd_o.addr <= {FILL_INSTANCE, fill_q.spare, fill_q.base + {6'h00, fill_idx_q}};
                nvm_cmd_o.rd   <= 1'b1;
            end
        end
    end

    // with the engine absent these stay at their reset levels
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ram_fill_addr_o  <= '0;
            ram_fill_data_o  <= '0;
            ram_fill_valid_o <= 1'b0;
            init_done_o      <= !INIT_ENABLED;
        end else if (ce_i && INIT_ENABLED) begin
            ram_fill_valid_o <= fill_word;
            if (fill_word) begin
                ram_fill_addr_o <= fill_idx_q;
                ram_fill_data_o <= nvm_rdata_i[8:0];
            end
            if (fill_start) begin
                init_done_o <= 1'b0;
            end else if (!fill_busy_q || (fill_word && fill_last)) begin
                init_done_o <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n || !ce_i);

    ready_err_a: assert property (pready_o && !pslverr_o) else $error("ready or slave error wrong");
    load_addr_a: assert property (ctrl_wr && pwdata_i[CTRL_LOAD] |=> addr_q == $past(addr_stage_q))
        else $error("address not loaded");
    stat_bits_a: assert property (setup_rd && paddr_i == OFS_STATUS |=>
        prdata_o[STAT_AUTOINC] == $past(autoinc_q) && prdata_o[STAT_FILL] == $past(fill_busy_q))
        else $error("status mode bits wrong");
    busy_bit_a: assert property (setup_rd && paddr_i == OFS_STATUS |=> prdata_o[STAT_BUSY] == $past(nvm_busy_i))
        else $error("busy bit not direct");
    err_set_a: assert property ((done_w || fill_word) && nvm_status_i != RESULT_OK |=> err_q && result_q == $past(nvm_status_i))
        else $error("error not flagged");
    err_hold_a: assert property (err_q && !(wr_acc && paddr_i == OFS_STATUS) |=> err_q)
        else $error("error cleared wrongly");
    page_stop_a: assert property (done_w && page_last && !ctrl_wr |=> $stable(addr_q))
        else $error("address moved past page end");
    step_a: assert property (done_w && autoinc_q && !page_last && kind_q != OP_PROGRAM && !ctrl_wr
        |=> addr_q == $past(addr_q) + AUTO_INC_STEP) else $error("address step wrong");
    read_keep_a: assert property (done_w && kind_q == OP_READ |=> rdata_q == $past(nvm_rdata_i) ##1 $stable(rdata_q))
        else $error("read data not held");
    toggle_a: assert property (ctrl_wr && pwdata_i[CTRL_AUTOINC] |=> autoinc_q != $past(autoinc_q))
        else $error("auto-increment not toggled");
    fill_block_a: assert property (fill_busy_q |-> !op_go ##1 !nvm_cmd_o.wr && !nvm_cmd_o.prog)
        else $error("bus operation during fill");
    fill_src_a: assert property (nvm_cmd_o.rd && fill_busy_q |-> nvm_cmd_o.addr[20:19] == FILL_INSTANCE)
        else $error("fill read from wrong instance");
    fill_pulse_a: assert property (ram_fill_valid_o |=> !ram_fill_valid_o)
        else $error("fill valid longer than one clock");
    absent_a: assert property (!INIT_ENABLED |-> init_done_o && !ram_fill_valid_o && ram_fill_addr_o == 12'h000)
        else $error("absent engine outputs wrong");

    read_done_c:  cover property (done_w && kind_q == OP_READ);
    write_done_c: cover property (done_w && kind_q == OP_WRITE);
    fill_done_c:  cover property (fill_word && fill_last);
    err_clear_c:  cover property (err_q ##1 !err_q);
endmodule : nvm_access

// ### verif/nvm_macro_model.sv
// behavioural memory macro that answers the access block's strobes
`timescale 1ns/100ps
module nvm_macro_model (
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    input  nvm_access_pkg::nvm_cmd_t cmd_i,
    input  wire logic [3:0]          lat_i,
    input  wire logic [1:0]          code_i,
    output logic                     busy_o,
    output logic      [1:0]          status_o,
    output logic      [31:0]         rdata_o,
    output logic      [31:0]         wdata_o,
    output logic      [20:0]         waddr_o
);
    import nvm_access_pkg::*;
    logic [3:0]  cnt_q;
    logic        pend_q;
    logic [20:0] addr_q;
    // busy stretches each answer by lat_i cycles, zero gives a prompt answer
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= 4'h0;
            pend_q <= 1'b0;
            addr_q <= 21'h000000;
        end else if (cmd_i.rd || cmd_i.wr || cmd_i.prog) begin
            cnt_q  <= lat_i;
            pend_q <= 1'b1;
            addr_q <= cmd_i.addr;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            pend_q <= 1'b0;
        end
    end
    // page buffer capture of the last written word
    always_ff @(posedge sys_clk_i) begin
        if (cmd_i.wr) begin
            wdata_o <= cmd_i.wdata;
            waddr_o <= cmd_i.addr;
        end
    end
    assign busy_o   = (cnt_q != 4'h0);
    // outside an answer the lines carry the inverse, so a late sample never matches
    assign status_o = pend_q ? code_i : ~code_i;
    assign rdata_o  = pend_q ? {11'h2AB, addr_q} : ~{11'h2AB, addr_q};
endmodule : nvm_macro_model

// ### verif/tb_nvm_access.sv
// self-checking bench for the nonvolatile memory access block
`timescale 1ns/100ps
module tb_nvm_access;
    import nvm_access_pkg::*;
    logic        sys_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        nvm_busy_i, ram_fill_valid_o, init_done_o, ce;
    logic [4:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, nvm_rdata_i, wdata_seen, rd_v;
    logic [1:0]  nvm_status_i, code;
    logic [3:0]  reload_req_i, lat;
    logic [11:0] ram_fill_addr_o;
    logic [8:0]  ram_fill_data_o;
    logic [20:0] waddr_seen;
    nvm_cmd_t    nvm_cmd_o;
    int          failures, total_checks;
    nvm_access dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .nvm_busy_i(nvm_busy_i), .nvm_status_i(nvm_status_i), .nvm_rdata_i(nvm_rdata_i),
        .nvm_cmd_o(nvm_cmd_o), .reload_req_i(reload_req_i), .ram_fill_addr_o(ram_fill_addr_o),
        .ram_fill_data_o(ram_fill_data_o), .ram_fill_valid_o(ram_fill_valid_o), .init_done_o(init_done_o));
    nvm_macro_model macro_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cmd_i(nvm_cmd_o), .lat_i(lat), .code_i(code),
        .busy_o(nvm_busy_i), .status_o(nvm_status_i), .rdata_o(nvm_rdata_i), .wdata_o(wdata_seen),
        .waddr_o(waddr_seen));
    always #12.5 sys_clk_i = ~sys_clk_i;
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : chk
    // one transfer; the bus holds everything until the access edge has passed
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(negedge sys_clk_i);
        psel_i   = 1'b1;
        pwrite_i = w;
        paddr_i  = a;
        pwdata_i = d;
        @(negedge sys_clk_i);
        penable_i = 1'b1;
        @(posedge sys_clk_i);
        rd_v = prdata_o;
        chk("ready", 32'h1, {31'h0, pready_o});
        chk("slave error", 32'h0, {31'h0, pslverr_o});
        @(negedge sys_clk_i);
        psel_i    = 1'b0;
        penable_i = 1'b0;
    endtask : apb
    // the strobe needs a few cycles to leave, so polling waits before the first look
    task automatic wait_op();
        int i;
        repeat (4) @(posedge sys_clk_i);
        for (i = 0; i < 50; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd_v[STAT_BUSY] === 1'b0) break;
        end
        if (i == 50) begin
            failures++;
            wrap_up();
        end
    endtask : wait_op
    task automatic fill_run(input logic [17:0] base, input logic [11:0] cnt);
        int i;
        int n;
        n = 0;
        for (i = 0; i < 3000; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (ram_fill_valid_o === 1'b1) begin
                chk("fill addr", 32'(n), {20'h0, ram_fill_addr_o});
                chk("fill data", {23'h0, 9'(base + 18'(n))}, {23'h0, ram_fill_data_o});
                n++;
            end
            if (init_done_o === 1'b1 && n > 0) break;
        end
        chk("fill words", {20'h0, cnt}, 32'(n));
        if (i == 3000) begin
            failures++;
            wrap_up();
        end
    endtask : fill_run
    task automatic s_page_end();
        apb(1'b1, OFS_ADDR1, 32'h78);
        apb(1'b1, OFS_CTRL, 32'h09);
        wait_op();
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("read data", {11'h2AB, 21'h78}, rd_v);
        apb(1'b0, OFS_ADDR1, 32'h0);
        chk("stepped address", 32'h7C, rd_v);
        lat = 4'h0;
        apb(1'b1, OFS_CTRL, 32'h08);
        wait_op();
        apb(1'b0, OFS_ADDR1, 32'h0);
        chk("held address", 32'h7C, rd_v);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("page end status", 32'h90, rd_v);
        lat = 4'h3;
    endtask : s_page_end
    task automatic s_codes();
        int c;
        apb(1'b1, OFS_WDATA, 32'hCAFE1234);
        for (c = 1; c < 4; c++) begin
            code = 2'(c);
            apb(1'b1, OFS_CTRL, 32'h04);
            wait_op();
            chk("written word", 32'hCAFE1234, wdata_seen);
            chk("written addr", 32'h7C, {11'h0, waddr_seen});
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("result code", 32'hB0 | 32'(c), rd_v);
            code = 2'h0;
            apb(1'b1, OFS_CTRL, 32'h04);
            wait_op();
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("sticky error", 32'hB0, rd_v);
            apb(1'b1, OFS_STATUS, 32'h0);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("cleared error", 32'h90, rd_v);
        end
        apb(1'b1, OFS_CTRL, 32'h10);
        wait_op();
        chk("program status", 32'h90, rd_v);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("read data kept", {11'h2AB, 21'h7C}, rd_v);
    endtask : s_codes
    task automatic s_autoinc();
        apb(1'b1, OFS_CTRL, 32'h80);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("step off", 32'h10, rd_v);
        apb(1'b1, OFS_ADDR1, 32'h40);
        apb(1'b1, OFS_CTRL, 32'h09);
        wait_op();
        apb(1'b0, OFS_ADDR1, 32'h0);
        chk("unstepped address", 32'h40, rd_v);
        apb(1'b1, OFS_CTRL, 32'h80);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("step on", 32'h80, rd_v);
        ce = 1'b0;
        apb(1'b1, OFS_CTRL, 32'h80);
        ce = 1'b1;
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("frozen toggle", 32'h80, rd_v);
    endtask : s_autoinc
    // a read issued during a copy must leave both address and read data alone
    task automatic s_reload();
        int k;
        apb(1'b1, OFS_ADDR1, 32'h100);
        apb(1'b1, OFS_CTRL, 32'h01);
        for (k = 0; k < 4; k++) begin
            @(negedge sys_clk_i);
            reload_req_i = 4'(1 << k);
            @(negedge sys_clk_i);
            reload_req_i = 4'h0;
            fork
                fill_run(CFG_BASE[k], CFG_COUNT[k]);
                begin
                    apb(1'b1, OFS_CTRL, 32'h08);
                    apb(1'b0, OFS_STATUS, 32'h0);
                    chk("fill busy", 32'h1, {31'h0, rd_v[STAT_FILL]});
                    chk("done during fill", 32'h0, {31'h0, init_done_o});
                end
            join
            apb(1'b0, OFS_ADDR1, 32'h0);
            chk("refused op", 32'h100, rd_v);
        end
        apb(1'b0, OFS_RDATA, 32'h0);
        chk("read data after fills", {11'h2AB, 21'h40}, rd_v);
    endtask : s_reload
    initial begin
        sys_clk_i    = 1'b0;
        rstn_i       = 1'b0;
        psel_i       = 1'b0;
        penable_i    = 1'b0;
        pwrite_i     = 1'b0;
        paddr_i      = 5'h00;
        pwdata_i     = 32'h0;
        reload_req_i = 4'h0;
        lat          = 4'h3;
        ce           = 1'b1;
        code         = 2'h0;
        failures     = 0;
        total_checks = 0;
        repeat (10) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        fill_run(CFG_BASE[CFG_RESET_IDX], CFG_COUNT[CFG_RESET_IDX]);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status after fill", 32'(STATUS_RESET), rd_v);
        s_page_end();
        s_codes();
        s_autoinc();
        s_reload();
        wrap_up();
    end
endmodule : tb_nvm_access
